/* File: src/dma_params.svh */
`ifndef DMA_PARAMS_SVH
`define DMA_PARAMS_SVH
// Summary of operation
// RULE_01 - Four engine registers; each channel has control, status, two pointers, counter.
// RULE_02 - Clearing module_on stops the engine and aborts every running transfer.
// RULE_03 - priority_scheme_select: 1 picks round-robin, 0 picks fixed priority.
// RULE_04 - Null write mode writes the buffer back to source after each destination write.
// RULE_05 - Reload restores pointers and counter when the next operation starts.
// RULE_06 - Repeated modes always reload the transaction counter.
// RULE_07 - Software request starts the channel; hardware clears it at completion.
// RULE_08 - Transfers done under a software request follow the transfer mode.
// RULE_09 - Source mode 11 indirect, 10 decrement, 01 increment by data size.
// RULE_10 - Destination mode 11 indirect, 10 decrement, 01 increment by data size.
// RULE_11 - Transfer mode: 11 repeated continuous, 10 continuous, 01 repeated one-shot, 00 one-shot.
// RULE_12 - Size bit 1 moves bytes, 0 moves 16-bit words.
// RULE_13 - channel_on enables the channel when set, disables when clear.
// RULE_14 - Pending flag reads 1 while the buffer still awaits its write.
// RULE_15 - Trigger select picks the start event; codes 000000 and 111101 start nothing.
// RULE_16 - High-limit flag sets on access above the upper limit or RAM top; the code sets it only for addresses above 07FFh.
// RULE_17 - Low-limit flag sets on access below lower limit but above 07FFh.
// RULE_18 - Limits are checked on the actual access, never in advance.
// RULE_19 - Done flag shows whether the last session ended with completion.
// RULE_20 - Overrun flag sets when a trigger arrives while the channel is busy.
// RULE_21 - A limit violation ends the transaction and raises the channel interrupt.
// RULE_22 - Round-robin rotates after each grant; fixed always grants the lowest.
// RULE_23 - In byte transfers the address LSB selects the upper or lower byte.
// RULE_24 - Six independently programmable channels.
// RULE_25 - Address mode 00 leaves the pointer unchanged.
// RULE_26 - Halfway flag at half count; interrupt there too when halfway_interrupt_on.

`define NUM_CHANNELS        6
`define OFS_ENGINE_CONTROL  8'h00
`define OFS_UPPER_LIMIT     8'h04
`define OFS_LOWER_LIMIT     8'h08
`define OFS_DATA_BUFFER     8'h0C
`define CH_WINDOW_FIRST     3'h1
`define CH_WINDOW_LAST      3'h6
`define SUB_CONTROL         3'h0
`define SUB_INTERRUPT       3'h1
`define SUB_SOURCE          3'h2
`define SUB_DESTINATION     3'h3
`define SUB_COUNTER         3'h4

`define BIT_MODULE_ON       15
`define BIT_PRIORITY        0
`define BIT_NULL_WRITE      10
`define BIT_RELOAD          9
`define BIT_SW_REQUEST      8
`define FLD_SRC_MODE        7:6
`define FLD_DST_MODE        5:4
`define FLD_XFER_MODE       3:2
`define BIT_SIZE            1
`define BIT_CHANNEL_ON      0
`define BIT_BUF_PENDING     15
`define FLD_TRIG_SEL        13:8
`define BIT_HIGH_LIMIT      7
`define BIT_LOW_LIMIT       6
`define BIT_DONE            5
`define BIT_HALFWAY         4
`define BIT_OVERRUN         3
`define BIT_HALF_IRQ_ON     0

`define CTRL_WRITE_MASK     16'h07FF
`define INTR_WRITE_MASK     16'h3FF9
`define REG_RESET           16'h0000
`define SFR_TOP             16'h07FF
`define DATA_RAM_TOP        16'hFFFF
`define TRIG_NONE           6'h00
`define TRIG_RESERVED       6'h3D
`define RR_LAST_RESET       3'h5

`endif

/* File: src/dma_pkg.sv */
package dma_pkg;

  typedef enum logic [2:0]
  {
    ST_IDLE   = 3'h0,
    ST_READ   = 3'h1,
    ST_WRITE  = 3'h3,
    ST_NULL   = 3'h2,
    ST_FINISH = 3'h6
  } eng_state_t;

  typedef enum logic [1:0]
  {
    ADDR_FIXED    = 2'h0,
    ADDR_INC      = 2'h1,
    ADDR_DEC      = 2'h2,
    ADDR_INDIRECT = 2'h3
  } addr_mode_t;

  typedef enum logic [1:0]
  {
    XFER_ONE_SHOT       = 2'h0,
    XFER_REP_ONE_SHOT   = 2'h1,
    XFER_CONTINUOUS     = 2'h2,
    XFER_REP_CONTINUOUS = 2'h3
  } xfer_mode_t;

  typedef struct packed
  {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [1:0]  be;
  } mem_cmd_t;

endpackage

/* File: src/multichannel_dma_controller.sv */
`timescale 1ns/1ns
`include "dma_params.svh"

module multichannel_dma_controller
(
  // System
  input  wire logic              core_clk,
  input  wire logic              reset,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output      logic [31:0]       wb_dat_o,
  output      logic              wb_ack_o,
  // Data bus master
  output      dma_pkg::mem_cmd_t mem_cmd,
  input  wire logic [15:0]       mem_rdata,
  input  wire logic              mem_ack,
  // Peripheral events
  input  wire logic [63:0]       trigger_events,
  input  wire logic [15:0]       pia_offset,
  output      logic [5:0]        channel_irq
);

  ////////////////////////////////////////////////////////////////////////////
  logic                  module_on;
  logic                  priority_scheme_select;
  logic [15:0]           upper_address_limit;
  logic [15:0]           lower_address_limit;
  logic [15:0]           transfer_data_buffer;
  logic                  buffer_write_pending_flag;
  logic [15:0]           channel_control [`NUM_CHANNELS];
  logic [15:0]           channel_interrupt_status [`NUM_CHANNELS];
  logic [15:0]           source_pointer [`NUM_CHANNELS];
  logic [15:0]           destination_pointer [`NUM_CHANNELS];
  logic [15:0]           transaction_counter [`NUM_CHANNELS];
  logic [15:0]           saved_source [`NUM_CHANNELS];
  logic [15:0]           saved_destination [`NUM_CHANNELS];
  logic [15:0]           saved_counter [`NUM_CHANNELS];
  logic [5:0]            active;
  logic [5:0]            reload_due;
  logic [5:0]            start;
  logic [5:0]            trig_hit;
  dma_pkg::eng_state_t   state;
  logic [2:0]            cur;
  logic [2:0]            last_grant;
  logic [2:0]            grant;
  logic                  err_high;
  logic                  err_low;
  logic                  bus_go;
  logic                  bus_wr;
  logic [15:0]           wmask;
  logic [15:0]           wval;
  logic [2:0]            ch_sel;
  logic                  ch_hit;
  logic [31:0]           next_rdata;
  logic [15:0]           src_eff;
  logic [15:0]           dst_eff;
  logic [15:0]           acc_addr;
  logic                  acc_high;
  logic                  acc_low;
  logic                  cur_byte;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone decode
  assign bus_go = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = bus_go & wb_we_i;
  assign wmask  = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign ch_sel = 3'(wb_adr_i[7:5] - `CH_WINDOW_FIRST);
  assign ch_hit = (wb_adr_i[7:5] >= `CH_WINDOW_FIRST)
                & (wb_adr_i[7:5] <= `CH_WINDOW_LAST) & (wb_adr_i[1:0] == 2'h0);

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] mask);
    merge = (old & ~mask) | (wb_dat_i[15:0] & mask);
  endfunction

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= bus_go;
      wb_dat_o <= bus_go ? next_rdata : 32'h0000_0000;
    end
  end

  // Read mux; unmapped words read zero
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (ch_hit)
    begin
      case (wb_adr_i[4:2])
        `SUB_CONTROL:     next_rdata[15:0] = channel_control[ch_sel];
        `SUB_INTERRUPT:
        begin
          next_rdata[15:0] = channel_interrupt_status[ch_sel];
          next_rdata[`BIT_BUF_PENDING] = buffer_write_pending_flag
                                         & (cur == ch_sel); // [RULE_14]
        end
        `SUB_SOURCE:      next_rdata[15:0] = source_pointer[ch_sel];
        `SUB_DESTINATION: next_rdata[15:0] = destination_pointer[ch_sel];
        `SUB_COUNTER:     next_rdata[15:0] = transaction_counter[ch_sel];
        default:          next_rdata = 32'h0000_0000;
      endcase
    end
    else
    begin
      case (wb_adr_i)
        `OFS_ENGINE_CONTROL:
        begin
          next_rdata[`BIT_MODULE_ON] = module_on;
          next_rdata[`BIT_PRIORITY]  = priority_scheme_select;
        end
        `OFS_UPPER_LIMIT: next_rdata[15:0] = upper_address_limit;
        `OFS_LOWER_LIMIT: next_rdata[15:0] = lower_address_limit;
        `OFS_DATA_BUFFER: next_rdata[15:0] = transfer_data_buffer;
        default:          next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Engine-level registers [RULE_01]
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      module_on              <= 1'b0;
      priority_scheme_select <= 1'b0;
      upper_address_limit    <= `REG_RESET;
      lower_address_limit    <= `REG_RESET;
    end
    else if (bus_wr && !ch_hit)
    begin
      case (wb_adr_i)
        `OFS_ENGINE_CONTROL:
        begin
          if (wb_sel_i[1])
            module_on <= wb_dat_i[`BIT_MODULE_ON];
          if (wb_sel_i[0])
            priority_scheme_select <= wb_dat_i[`BIT_PRIORITY];
        end
        `OFS_UPPER_LIMIT:
          upper_address_limit <= merge(upper_address_limit, wmask);
        `OFS_LOWER_LIMIT:
          lower_address_limit <= merge(lower_address_limit, wmask);
        default:
          upper_address_limit <= upper_address_limit;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start and overrun detection
  always_comb
  begin
    for (int i = 0; i < `NUM_CHANNELS; i++)
    begin
      trig_hit[i] = trigger_events[channel_interrupt_status[i][`FLD_TRIG_SEL]]
        & (channel_interrupt_status[i][`FLD_TRIG_SEL] != `TRIG_NONE)
        & (channel_interrupt_status[i][`FLD_TRIG_SEL] != `TRIG_RESERVED);
      // [RULE_15]
      start[i] = module_on & channel_control[i][`BIT_CHANNEL_ON] & ~active[i]
        & (trig_hit[i] | channel_control[i][`BIT_SW_REQUEST]);
      // [RULE_07] [RULE_13]
    end
  end

  // Arbiter: fixed from channel 0, or rotating after the last grant
  always_comb
  begin
    logic found;
    int   j;
    j     = 0;
    found = 1'b0;
    grant = 3'h0;
    for (int k = 0; k < `NUM_CHANNELS; k++)
    begin
      j = priority_scheme_select ? (int'(last_grant) + 1 + k) % `NUM_CHANNELS
                                 : k; // [RULE_03] [RULE_22]
      if (!found && active[j])
      begin
        found = 1'b1;
        grant = 3'(j);
      end
    end
  end

  // Effective addresses and limit check on the access itself
  always_comb
  begin
    src_eff = source_pointer[cur];
    dst_eff = destination_pointer[cur];
    if (channel_control[cur][`FLD_SRC_MODE] == dma_pkg::ADDR_INDIRECT)
      src_eff = 16'(source_pointer[cur] + pia_offset); // [RULE_09]
    if (channel_control[cur][`FLD_DST_MODE] == dma_pkg::ADDR_INDIRECT)
      dst_eff = 16'(destination_pointer[cur] + pia_offset); // [RULE_10]
    acc_addr = (state == dma_pkg::ST_WRITE) ? dst_eff : src_eff;
    acc_high = (acc_addr > `SFR_TOP) & ((acc_addr > upper_address_limit)
               | (acc_addr > `DATA_RAM_TOP)); // [RULE_16]
    acc_low  = (acc_addr > `SFR_TOP) & (acc_addr < lower_address_limit);
    // [RULE_17]
    cur_byte = channel_control[cur][`BIT_SIZE]; // [RULE_12]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer engine
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      state                     <= dma_pkg::ST_IDLE;
      cur                       <= 3'h0;
      last_grant                <= `RR_LAST_RESET;
      mem_cmd                   <= '0;
      transfer_data_buffer      <= `REG_RESET;
      buffer_write_pending_flag <= 1'b0;
      err_high                  <= 1'b0;
      err_low                   <= 1'b0;
    end
    else if (!module_on)
    begin
      state                     <= dma_pkg::ST_IDLE; // [RULE_02]
      mem_cmd.req               <= 1'b0;
      buffer_write_pending_flag <= 1'b0;
    end
    else
    begin
      case (state)
        dma_pkg::ST_IDLE:
        begin
          err_high <= 1'b0;
          err_low  <= 1'b0;
          if (|active)
          begin
            cur        <= grant;
            last_grant <= grant; // [RULE_22]
            state      <= dma_pkg::ST_READ;
          end
        end
        dma_pkg::ST_READ, dma_pkg::ST_WRITE, dma_pkg::ST_NULL:
        begin
          if (mem_cmd.req)
          begin
            if (mem_ack)
            begin
              mem_cmd.req <= 1'b0;
              if (state == dma_pkg::ST_READ)
              begin
                // [RULE_23]
                transfer_data_buffer <= !cur_byte ? mem_rdata
                  : mem_cmd.addr[0] ? {8'h00, mem_rdata[15:8]}
                  : {8'h00, mem_rdata[7:0]};
                buffer_write_pending_flag <= 1'b1; // [RULE_14]
                state <= dma_pkg::ST_WRITE;
              end
              else if (state == dma_pkg::ST_WRITE
                       && channel_control[cur][`BIT_NULL_WRITE])
                state <= dma_pkg::ST_NULL; // [RULE_04]
              else
              begin
                buffer_write_pending_flag <= 1'b0; // [RULE_14]
                state <= dma_pkg::ST_FINISH;
              end
            end
          end
          else if (!mem_ack)
          begin
            if (acc_high || acc_low)
            begin
              err_high <= acc_high; // [RULE_18] [RULE_21]
              err_low  <= acc_low;
              buffer_write_pending_flag <= 1'b0;
              state    <= dma_pkg::ST_FINISH;
            end
            else
            begin
              mem_cmd.req   <= 1'b1;
              mem_cmd.we    <= (state != dma_pkg::ST_READ);
              mem_cmd.addr  <= acc_addr;
              mem_cmd.wdata <= cur_byte ? {2{transfer_data_buffer[7:0]}}
                                        : transfer_data_buffer; // [RULE_23]
              mem_cmd.be    <= !cur_byte ? 2'h3
                               : acc_addr[0] ? 2'h2 : 2'h1;
            end
          end
        end
        dma_pkg::ST_FINISH:
          state <= dma_pkg::ST_IDLE;
        default:
          state <= dma_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel registers and session control [RULE_24]
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      active      <= 6'h00;
      reload_due  <= 6'h00;
      channel_irq <= 6'h00;
      for (int i = 0; i < `NUM_CHANNELS; i++)
      begin
        channel_control[i]          <= `REG_RESET;
        channel_interrupt_status[i] <= `REG_RESET;
        source_pointer[i]           <= `REG_RESET;
        destination_pointer[i]      <= `REG_RESET;
        transaction_counter[i]      <= `REG_RESET;
        saved_source[i]             <= `REG_RESET;
        saved_destination[i]        <= `REG_RESET;
        saved_counter[i]            <= `REG_RESET;
      end
    end
    else
    begin
      channel_irq <= 6'h00;
      for (int i = 0; i < `NUM_CHANNELS; i++)
      begin
        logic [15:0] step;
        logic        last;
        logic        rep;
        step = channel_control[i][`BIT_SIZE] ? 16'h0001 : 16'h0002;
        last = transaction_counter[i] <= 16'h0001;
        rep  = channel_control[i][2]; // Repeated modes have bit 2 set [RULE_11]
        // Software side first, so hardware events below win
        if (bus_wr && ch_hit && ch_sel == 3'(i))
        begin
          case (wb_adr_i[4:2])
            `SUB_CONTROL:
              channel_control[i] <= merge(channel_control[i],
                                          wmask & `CTRL_WRITE_MASK);
            `SUB_INTERRUPT:
              channel_interrupt_status[i] <= merge(channel_interrupt_status[i],
                                                   wmask & `INTR_WRITE_MASK);
            `SUB_SOURCE:
            begin
              source_pointer[i] <= merge(source_pointer[i], wmask);
              saved_source[i]   <= merge(source_pointer[i], wmask);
            end
            `SUB_DESTINATION:
            begin
              destination_pointer[i] <= merge(destination_pointer[i], wmask);
              saved_destination[i]   <= merge(destination_pointer[i], wmask);
            end
            `SUB_COUNTER:
            begin
              transaction_counter[i] <= merge(transaction_counter[i], wmask);
              saved_counter[i]       <= merge(transaction_counter[i], wmask);
            end
            default:
              active[i] <= active[i];
          endcase
        end
        if (!module_on || !channel_control[i][`BIT_CHANNEL_ON])
          active[i] <= 1'b0; // [RULE_02] [RULE_13]
        else if (trig_hit[i] && active[i])
          channel_interrupt_status[i][`BIT_OVERRUN] <= 1'b1; // [RULE_20]
        if (start[i])
        begin
          active[i] <= 1'b1;
          channel_interrupt_status[i][`BIT_DONE] <= 1'b0; // [RULE_19]
          if (reload_due[i])
          begin
            reload_due[i] <= 1'b0;
            transaction_counter[i] <= saved_counter[i]; // [RULE_05] [RULE_06]
            if (channel_control[i][`BIT_RELOAD])
            begin
              source_pointer[i]      <= saved_source[i]; // [RULE_05]
              destination_pointer[i] <= saved_destination[i];
            end
          end
        end
        if (state == dma_pkg::ST_FINISH && cur == 3'(i) && module_on)
        begin
          if (err_high || err_low)
          begin
            channel_interrupt_status[i][`BIT_HIGH_LIMIT] <= err_high;
            channel_interrupt_status[i][`BIT_LOW_LIMIT]  <= err_low;
            active[i]      <= 1'b0; // [RULE_21]
            channel_control[i][`BIT_SW_REQUEST] <= 1'b0;
            channel_irq[i] <= 1'b1;
          end
          else
          begin
            // [RULE_09] [RULE_10] [RULE_25]
            if (channel_control[i][`FLD_SRC_MODE] == dma_pkg::ADDR_INC)
              source_pointer[i] <= 16'(source_pointer[i] + step);
            else if (channel_control[i][`FLD_SRC_MODE] == dma_pkg::ADDR_DEC)
              source_pointer[i] <= 16'(source_pointer[i] - step);
            if (channel_control[i][`FLD_DST_MODE] == dma_pkg::ADDR_INC)
              destination_pointer[i] <= 16'(destination_pointer[i] + step);
            else if (channel_control[i][`FLD_DST_MODE] == dma_pkg::ADDR_DEC)
              destination_pointer[i] <= 16'(destination_pointer[i] - step);
            transaction_counter[i] <= 16'(transaction_counter[i] - 16'h0001);
            if (16'(transaction_counter[i] - 16'h0001)
                == (saved_counter[i] >> 1) && !last)
            begin
              channel_interrupt_status[i][`BIT_HALFWAY] <= 1'b1; // [RULE_26]
              if (channel_interrupt_status[i][`BIT_HALF_IRQ_ON])
                channel_irq[i] <= 1'b1;
            end
            // One-shot modes stop after each transfer [RULE_08] [RULE_11]
            if (!channel_control[i][3] || last)
              active[i] <= 1'b0;
            if (last)
            begin
              channel_interrupt_status[i][`BIT_DONE] <= 1'b1; // [RULE_19]
              channel_control[i][`BIT_SW_REQUEST]    <= 1'b0; // [RULE_07]
              channel_irq[i] <= 1'b1;
              reload_due[i]  <= rep | channel_control[i][`BIT_RELOAD];
              if (!rep)
                channel_control[i][`BIT_CHANNEL_ON] <= 1'b0;
            end
          end
        end
      end
    end
  end

endmodule

/* File: testbench/dma_mem_model.sv */
`timescale 1ns/1ns
module dma_mem_model
(
  // System
  input  wire logic              core_clk,
  input  wire logic              reset,
  // Data bus
  input  wire dma_pkg::mem_cmd_t mem_cmd,
  output      logic [15:0]       mem_rdata,
  output      logic              mem_ack
);
  logic [15:0] mem [0:32767];
  logic [1:0]  wait_cnt;
  logic [1:0]  slow;
  // Latency cycles 0..3 across accesses
  always @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      mem_ack   <= 1'b0;
      wait_cnt  <= 2'h0;
      slow      <= 2'h0;
      mem_rdata <= 16'h5A5A;
    end
    else if (mem_ack)
    begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      slow      <= slow + 2'h1;
    end
    else if (mem_cmd.req && wait_cnt != slow)
      wait_cnt <= wait_cnt + 2'h1;
    else if (mem_cmd.req)
    begin
      mem_ack  <= 1'b1;
      wait_cnt <= 2'h0;
      if (!mem_cmd.we)
        mem_rdata <= mem[mem_cmd.addr[15:1]];
      if (mem_cmd.we && mem_cmd.be[0])
        mem[mem_cmd.addr[15:1]][7:0] <= mem_cmd.wdata[7:0];
      if (mem_cmd.we && mem_cmd.be[1])
        mem[mem_cmd.addr[15:1]][15:8] <= mem_cmd.wdata[15:8];
    end
  end
endmodule

/* File: testbench/dma_monitor.sv */
`timescale 1ns/1ns
module dma_monitor
(
  // System
  input wire logic              core_clk,
  input wire logic              reset,
  // Register bus
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [7:0]        wb_adr_i,
  input wire logic [31:0]       wb_dat_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_ack_o,
  // Data bus
  input wire dma_pkg::mem_cmd_t mem_cmd,
  input wire logic              mem_ack,
  // Events
  input wire logic [5:0]        channel_irq
);
  logic [15:0] upper_lim;
  logic [15:0] lower_lim;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Shadow of the limit registers
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      upper_lim <= 16'h0000;
      lower_lim <= 16'h0000;
    end
    else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o)
    begin
      if (wb_adr_i == 8'h04)
        upper_lim <= wb_dat_i[15:0];
      if (wb_adr_i == 8'h08)
        lower_lim <= wb_dat_i[15:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_wb_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_mem_wait;
    mem_cmd.req && !mem_ack;
  endsequence
  property p_wb_ack;
    s_wb_req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("ack");
  property p_idle_data;
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000;
  endproperty
  a_idle_data: assert property (p_idle_data) else $error("idle");
  property p_req_hold;
    s_mem_wait |=> mem_cmd.req && $stable(mem_cmd.addr) && $stable(mem_cmd.we);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("req moved");
  property p_req_drop;
    mem_cmd.req && mem_ack |=> !mem_cmd.req;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("req held");
  property p_byte_lane;
    mem_cmd.req && mem_cmd.be != 2'b11 |->
      mem_cmd.be == {mem_cmd.addr[0], !mem_cmd.addr[0]};
  endproperty
  a_byte_lane: assert property (p_byte_lane) else $error("lane");
  property p_byte_dup;
    mem_cmd.req && mem_cmd.we && mem_cmd.be != 2'b11 |->
      mem_cmd.wdata[15:8] == mem_cmd.wdata[7:0];
  endproperty
  a_byte_dup: assert property (p_byte_dup) else $error("dup");
  property p_limits;
    mem_cmd.req && mem_cmd.addr > 16'h07FF |->
      mem_cmd.addr <= upper_lim && mem_cmd.addr >= lower_lim;
  endproperty
  a_limits: assert property (p_limits) else $error("lim");
  property p_irq_pulse;
    channel_irq != 6'h00 |=> (channel_irq & $past(channel_irq)) == 6'h00;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq long");
endmodule
bind multichannel_dma_controller dma_monitor u_mon (.*);

/* File: testbench/multichannel_dma_controller_tb_top.sv */
`timescale 1ns/1ns
module multichannel_dma_controller_tb_top;
  logic              core_clk = 1'b0;
  logic              reset = 1'b1;
  logic              wb_cyc_i = 1'b0;
  logic              wb_stb_i = 1'b0;
  logic              wb_we_i = 1'b0;
  logic [7:0]        wb_adr_i = 8'h00;
  logic [3:0]        wb_sel_i = 4'h0;
  logic [31:0]       wb_dat_i = 32'h0000_0000;
  logic [31:0]       wb_dat_o;
  logic              wb_ack_o;
  logic              mem_ack;
  logic [15:0]       mem_rdata;
  logic [15:0]       rd;
  logic [63:0]       trigger_events = 64'h0000_0000_0000_0000;
  logic [5:0]        channel_irq;
  dma_pkg::mem_cmd_t mem_cmd;
  int                n_fail = 0;
  int                check_count = 0;
  always #10 core_clk = ~core_clk;
  multichannel_dma_controller dut (.core_clk, .reset, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .mem_cmd, .mem_rdata, .mem_ack, .trigger_events,
    .pia_offset(16'h0000), .channel_irq);
  dma_mem_model mem_i (.core_clk, .reset, .mem_cmd, .mem_rdata, .mem_ack);
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string w, input logic [15:0] e, g);
    check_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [15:0] d);
    int n = 0;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= {16'h0000, d};
    wb_sel_i <= 4'h3;
    @(posedge core_clk);
    while (wb_ack_o !== 1'b1 && n < 50)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n == 50)
      n_fail++;
    if (n == 50)
      finish_test();
    rd = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] e, input string s);
    bus(a, 1'b0, 16'h0000);
    check(s, e, rd);
  endtask
  task automatic setup(input int ch, input logic [15:0] v [5]);
    for (int s = 1; s < 6; s++)
      wr({3'(ch + 1), 3'(s % 5), 2'b00}, v[s % 5]);
  endtask
  task automatic wait_irq(input int ch);
    int n = 0;
    @(posedge core_clk);
    while (channel_irq[ch] !== 1'b1 && n < 500)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n == 500)
      n_fail++;
    if (n == 500)
      finish_test();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    mem_i.mem[16'h0400] = 16'h1234;
    mem_i.mem[16'h0401] = 16'h5678;
    mem_i.mem[16'h0500] = 16'hAB00;
    mem_i.mem[16'h0580] = 16'h0000;
    mem_i.mem[16'h04C8] = 16'hDEAD;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    rdc(8'h00, 16'h0000, "engine reset");
    for (int c = 0; c < 6; c++)
      rdc({3'(c + 1), 5'h00}, 16'h0000, "control reset");
    wr(8'h00, 16'hFFFF);
    rdc(8'h00, 16'h8001, "engine bits");
    wr(8'hC0, 16'hFEFE);
    rdc(8'hC0, 16'h06FE, "control mask");
    wr(8'hC4, 16'hFFFF);
    rdc(8'hC4, 16'h3FF9, "status mask");
    rdc(8'h10, 16'h0000, "unmapped");
    $display("test registers done");
    wr(8'h04, 16'h0FFF);
    wr(8'h08, 16'h0800);
    setup(0, '{16'h0159, 16'h0000, 16'h0800, 16'h0900, 16'h0002});
    wait_irq(0);
    check("dst word 0", 16'h1234, mem_i.mem[16'h0480]);
    check("dst word 1", 16'h5678, mem_i.mem[16'h0481]);
    rdc(8'h28, 16'h0804, "src after");
    rdc(8'h20, 16'h0058, "control after");
    rdc(8'h24, 16'h0030, "done flags");
    setup(1, '{16'h0183, 16'h0000, 16'h0A01, 16'h0B00, 16'h0001});
    wait_irq(1);
    check("byte moved", 16'h00AB, mem_i.mem[16'h0580]);
    rdc(8'h48, 16'h0A00, "src dec");
    rdc(8'h4C, 16'h0B00, "dst fixed");
    $display("test transfers done");
    setup(2, '{16'h0101, 16'h0000, 16'h2000, 16'h0900, 16'h0001});
    wait_irq(2);
    bus(8'h64, 1'b0, 16'h0000);
    check("high limit", 16'h0080, rd & 16'h00A0);
    setup(3, '{16'h0001, 16'h0500, 16'h0800, 16'h0980, 16'h0001});
    trigger_events <= 64'h0000_0000_0000_0020;
    @(posedge core_clk);
    trigger_events <= 64'h0000_0000_0000_0000;
    wait_irq(3);
    check("triggered", 16'h1234, mem_i.mem[16'h04C0]);
    wr(8'h00, 16'h0000);
    setup(4, '{16'h0101, 16'h0000, 16'h0800, 16'h0990, 16'h0001});
    repeat (60) @(posedge core_clk);
    check("module off", 16'hDEAD, mem_i.mem[16'h04C8]);
    $display("test events done");
    finish_test();
  end
endmodule
